// >>> bench/ffsc_chk.sv
`timescale 1ns/1ns
module ffsc_chk (
    input wire logic clk_in, rst_in, step_out, busy_out, int_out, wr_strobe_out, // Clock, reset and core outputs.
    input wire logic s_axi_arvalid_in, s_axi_arready_out, s_axi_rvalid_out, s_axi_rready_in, // Reads.
    input wire logic s_axi_awvalid_in, s_axi_bvalid_out, s_axi_bready_in, // Writes.
    input wire logic [7:0] wr_byte_out // Track byte.
);
    // One clock domain, so clock and reset are given once.
    default clocking @(posedge clk_in); endclocking
    default disable iff (rst_in);
    AST_BUSY_PULSE: assert property (busy_out |=> !busy_out)
        else $error("busy held into execution");
    AST_STEP_GAP: assert property (step_out |=> !step_out)
        else $error("steps not spaced");
    AST_NO_STEP_FMT: assert property (!(step_out && wr_strobe_out))
        else $error("step while writing track");
    AST_LEAD_GAP: assert property ($rose(wr_strobe_out) |-> wr_byte_out inside {8'h4E, 8'hFF})
        else $error("track does not open with gap");
    AST_INT_HOLD: assert property (int_out && !s_axi_arvalid_in && !s_axi_rvalid_out && !s_axi_awvalid_in
        |=> int_out)
        else $error("interrupt lost without sense");
    AST_R_LAT: assert property (s_axi_arvalid_in && s_axi_arready_out |=> s_axi_rvalid_out)
        else $error("read answer late");
    AST_R_HOLD: assert property (s_axi_rvalid_out && !s_axi_rready_in |=> s_axi_rvalid_out)
        else $error("rvalid dropped");
    AST_B_HOLD: assert property (s_axi_bvalid_out && !s_axi_bready_in |=> s_axi_bvalid_out)
        else $error("bvalid dropped");
    C_STEP: cover property (step_out);
    C_INT: cover property (int_out);
    C_FMT: cover property (wr_strobe_out);
endmodule : ffsc_chk
bind ffsc_top ffsc_chk u_chk (.*);

// >>> bench/ffsc_drive.sv
`timescale 1ns/1ns
module ffsc_drive #(parameter int REV = 600) (
    input wire logic clk_in, step_in, dir_in, dead_in, ids_in, // Head control and fault knobs.
    output logic index_out, track0_out, id_ok_out, // Sense lines.
    output logic [31:0] id_out // Decoded ID field.
);
    logic [7:0] cyl = 8'h05;
    int ph = 1;
    // The head moves one cylinder a step and stops at zero.
    always @(posedge clk_in)
    begin
        ph <= (ph == REV - 1) ? 0 : ph + 1;
        if (step_in) cyl <= dir_in ? cyl + 8'h01 : cyl - {7'h00, cyl != 8'h00};
    end
    // Short index pulse each turn; ID data is garbage outside its field.
    assign index_out = ph < 4;
    assign track0_out = cyl == 8'h00 && !dead_in;
    assign id_ok_out = ids_in && ph == REV / 2;
    assign id_out = {cyl, 24'h000102} ^ {32{!id_ok_out}};
endmodule : ffsc_drive

// >>> bench/ffsc_top_tb.sv
`timescale 1ns/1ns
module ffsc_top_tb;
    logic clk = 1'h0, rst = 1'h1, awv = 1'h0, wv = 1'h0, brd = 1'h0, arv = 1'h0, rrd = 1'h0;
    logic dead = 1'h0, ids = 1'h0, awr, wr, bv, ar, rv, step, dir, ws, busy, irq, idx, t0, idok;
    logic [31:0] awa = 32'h0, wd = 32'h0, ara = 32'h0, rdat, idv, q;
    logic [1:0] bresp, rresp, rsp;
    logic [7:0] wb;
    logic [7:0] trk[$];
    int failures = 0, checks_done = 0, n_in = 0, n_out = 0, n_busy = 0;
    ffsc_top #(.STEP_DIV(1)) dut (.clk_in(clk), .rst_in(rst), .s_axi_awaddr_in(awa), .s_axi_awvalid_in(awv),
        .s_axi_awready_out(awr), .s_axi_wdata_in(wd), .s_axi_wstrb_in(4'hF), .s_axi_wvalid_in(wv),
        .s_axi_wready_out(wr), .s_axi_bresp_out(bresp), .s_axi_bvalid_out(bv), .s_axi_bready_in(brd),
        .s_axi_araddr_in(ara), .s_axi_arvalid_in(arv), .s_axi_arready_out(ar), .s_axi_rdata_out(rdat),
        .s_axi_rresp_out(rresp), .s_axi_rvalid_out(rv), .s_axi_rready_in(rrd), .index_pulse_in(idx),
        .track0_sense_in(t0), .rd_id_valid_in(idok), .rd_id_in(idv), .step_out(step),
        .step_direction_out(dir), .wr_byte_out(wb), .wr_strobe_out(ws), .wr_crc_out(), .busy_out(busy),
        .int_out(irq));
    ffsc_drive #(.REV(600)) drv (.clk_in(clk), .step_in(step), .dir_in(dir), .dead_in(dead), .ids_in(ids),
        .index_out(idx), .track0_out(t0), .id_ok_out(idok), .id_out(idv));
    initial forever #4 clk = !clk;
    // Pulses are counted at the falling edge, where the registered outputs have settled.
    always @(negedge clk)
    begin
        if (busy) n_busy++;
        if (step) if (dir) n_in++; else n_out++;
        if (ws) trk.push_back(wb);
    end
    task automatic chk(input string nm, input logic [31:0] e, g);
        checks_done++;
        if (g !== e)
        begin
            $display("mismatch %s expected %h seen %h", nm, e, g);
            failures++;
        end
    endtask : chk
    // Outputs are sampled at the falling edge, where they are settled.
    task automatic bus(input logic w, input logic [31:0] a, d);
        int n;
        logic [3:0] h;
        @(posedge clk);
        if (w) {awv, wv, brd} <= 3'h7;
        else {arv, rrd} <= 2'h3;
        {awa, ara, wd} <= {a, a, d};
        for (n = 0; n < 99; n++)
        begin
            @(negedge clk);
            h = {awr, wr, ar, bv | rv};
            {q, rsp} = {rdat, bv ? bresp : rresp};
            @(posedge clk);
            if (h[3]) awv <= 1'h0;
            if (h[2]) wv <= 1'h0;
            if (h[1]) arv <= 1'h0;
            if (h[0]) break;
        end
        {brd, rrd} <= 2'h0;
        if (n == 99) chk("bus", 1, 0);
        if (n == 99) tally_and_finish();
    endtask : bus
    task automatic cmd(input logic [31:0] d, input logic wait_irq);
        int n;
        {n_in, n_out, n_busy} = 0;
        bus(1'h1, ffsc_pkg::ADDR_CMD, d);
        chk("busy", 1, n_busy);
        for (n = 0; n < 3000 && wait_irq && irq !== 1'h1; n++) @(negedge clk);
        if (n == 3000) chk("irq", 1, 0);
        if (n == 3000) tally_and_finish();
    endtask : cmd
    task automatic sense(input logic [15:0] e);
        bus(1'h0, ffsc_pkg::ADDR_SENSE, 32'h0);
        chk("sense", {16'h0, e}, q & 32'hFFFF);
        @(negedge clk);
        chk("irq", 0, irq);
    endtask : sense
    task automatic t_seek;
        bus(1'h1, ffsc_pkg::ADDR_CTRL, 32'h0201_A503);
        cmd(32'h3, 1'h1);
        chk("out", 5, n_out);
        sense(16'h0020);
        cmd(32'h0304, 1'h1);
        chk("in", 3, n_in);
        sense(16'h0320);
        cmd(32'h0104, 1'h1);
        chk("out", 2, n_out);
        sense(16'h0120);
        cmd(32'h0104, 1'h1);
        chk("none", 0, n_in + n_out);
        sense(16'h0120);
        $display("seek test done");
    endtask : t_seek
    task automatic t_readid;
        ids <= 1'h1;
        cmd(32'h2, 1'h1);
        bus(1'h0, ffsc_pkg::ADDR_RID, 32'h0);
        chk("rid", 32'h0100_0102, q);
        sense(16'h0100);
        ids <= 1'h0;
        cmd(32'h2, 1'h1);
        bus(1'h0, ffsc_pkg::ADDR_STAT, 32'h0);
        chk("miss", 1, q[16]);
        sense(16'h0140);
        bus(1'h0, 32'h20, 32'h0);
        chk("resp", 2, rsp);
        cmd(32'h5, 1'h0);
        cmd(32'h6, 1'h0);
        sense(16'h0000);
        $display("read id test done");
    endtask : t_readid
    task automatic t_format(input logic mfm);
        int p[8];
        logic [7:0] v[8];
        int i, a5;
        p = '{0, 80, 92, 95, 96, 158, 161, 162};
        v = '{8'h4E, 0, 8'hC2, 8'hFC, 8'h4E, 8'hA1, 8'hFE, 1};
        if (!mfm)
        begin
            p = '{0, 39, 40, 46, 47, 73, 79, 80};
            v = '{8'hFF, 8'hFF, 0, 8'hFC, 8'hFF, 0, 8'hFE, 1};
        end
        bus(1'h1, ffsc_pkg::ADDR_CTRL, {24'h0201_A5, 7'h01, mfm});
        bus(1'h1, ffsc_pkg::ADDR_IDB, 32'h0100_0300);
        trk.delete();
        cmd(32'h1, 1'h0);
        repeat (1300) @(posedge clk);
        for (i = 0; i < 8; i++) chk("byte", v[i], trk[p[i]]);
        a5 = 0;
        foreach (trk[j]) a5 += trk[j] == 8'hA5;
        chk("fill", 1, a5 >= 128);
        chk("end", 1, trk.size() < 600);
        chk("noirq", 0, irq);
        $display("format test done");
    endtask : t_format
    task automatic t_fail;
        dead <= 1'h1;
        cmd(32'h3, 1'h1);
        chk("steps", 79, n_out);
        bus(1'h0, ffsc_pkg::ADDR_SENSE, 32'h0);
        chk("flags", 3, q[5:4]);
        $display("recal fault test done");
    endtask : t_fail
    task automatic tally_and_finish;
        $display("checks %0d mismatches %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : tally_and_finish
    initial
    begin
        repeat (3) @(posedge clk);
        rst <= 1'h0;
        t_seek();
        t_readid();
        t_format(1'h1);
        t_format(1'h0);
        t_fail();
        tally_and_finish();
    end
endmodule : ffsc_top_tb

// >>> rtl/ffsc_pkg.sv
package ffsc_pkg;
    localparam logic [31:0] ADDR_CTRL = 32'h0000_0000;
    localparam logic [31:0] ADDR_CMD = 32'h0000_0004;
    localparam logic [31:0] ADDR_IDB = 32'h0000_0008;
    localparam logic [31:0] ADDR_STAT = 32'h0000_000C;
    localparam logic [31:0] ADDR_RID = 32'h0000_0010;
    localparam logic [31:0] ADDR_SENSE = 32'h0000_0014;
    localparam logic [2:0] CMD_FORMAT = 3'h1;
    localparam logic [2:0] CMD_READID = 3'h2;
    localparam logic [2:0] CMD_RECAL = 3'h3;
    localparam logic [2:0] CMD_SEEK = 3'h4;
    localparam logic [2:0] CMD_PDOWN = 3'h5;
    localparam logic [2:0] CMD_PUP = 3'h6;
    localparam logic [7:0] RECAL_MAX = 8'h4F;
    localparam logic [7:0] GAP_MFM = 8'h4E;
    localparam logic [7:0] GAP_FM = 8'hFF;
    localparam logic [7:0] SYNC_BYTE = 8'h00;
    localparam logic [7:0] IAM_MFM_PRE = 8'hC2;
    localparam logic [7:0] IDM_MFM_PRE = 8'hA1;
    localparam logic [7:0] MARK_INDEX = 8'hFC;
    localparam logic [7:0] MARK_ID = 8'hFE;
    localparam logic [7:0] MARK_DATA = 8'hFB;
    localparam logic [7:0] MARK_DEL = 8'hF8;
    localparam logic [7:0] MFM_GAP4A = 8'h50;
    localparam logic [7:0] MFM_SYNC = 8'h0C;
    localparam logic [7:0] MFM_GAP1 = 8'h32;
    localparam logic [7:0] MFM_GAP2 = 8'h16;
    localparam logic [7:0] FM_GAP4A = 8'h28;
    localparam logic [7:0] FM_SYNC = 8'h06;
    localparam logic [7:0] FM_GAP1 = 8'h1A;
    localparam logic [7:0] FM_GAP2 = 8'h0B;
    localparam logic [7:0] PREFIX_CNT = 8'h03;
    localparam logic [1:0] IC_NORMAL = 2'h0;
    localparam logic [1:0] IC_ABNORMAL = 2'h1;
    localparam int ST0_SE = 5;
    localparam int ST0_EC = 4;
    localparam int ST0_HD = 2;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;
    localparam logic [2:0] FMT_IAM_BYTE = 3'h0;
    typedef enum logic [3:0] {
        FFSC_IDLE = 4'b0000,
        FFSC_WAIT_IDX = 4'b0001,
        FFSC_GAP4A = 4'b0010,
        FFSC_SYNC_I = 4'b0011,
        FFSC_IAM = 4'b0100,
        FFSC_GAP1 = 4'b0101,
        FFSC_SYNC_ID = 4'b0110,
        FFSC_ID_MARK = 4'b0111,
        FFSC_IDF = 4'b1000,
        FFSC_GAP2 = 4'b1001,
        FFSC_SYNC_D = 4'b1010,
        FFSC_DAM = 4'b1011,
        FFSC_DATA = 4'b1100,
        FFSC_GAP3 = 4'b1101,
        FFSC_STEP = 4'b1110,
        FFSC_READID = 4'b1111
    } ffsc_state_t;
endpackage : ffsc_pkg

// >>> rtl/ffsc_top.sv
// Our own choices: the AXI4-Lite register port and the placing of the registers.
`timescale 1ns/1ns
module ffsc_top #(
    parameter int STEP_DIV = 1000 // Clock cycles per step interval unit.
) (
    input wire logic clk_in, // 125 MHz clock.
    input wire logic rst_in, // Synchronous reset, high.
    input wire logic [31:0] s_axi_awaddr_in, // Write address.
    input wire logic s_axi_awvalid_in, // Write address valid.
    output logic s_axi_awready_out, // Write address ready.
    input wire logic [31:0] s_axi_wdata_in, // Write data.
    input wire logic [3:0] s_axi_wstrb_in, // Write strobes.
    input wire logic s_axi_wvalid_in, // Write data valid.
    output logic s_axi_wready_out, // Write data ready.
    output logic [1:0] s_axi_bresp_out, // Write response.
    output logic s_axi_bvalid_out, // Write response valid.
    input wire logic s_axi_bready_in, // Write response ready.
    input wire logic [31:0] s_axi_araddr_in, // Read address.
    input wire logic s_axi_arvalid_in, // Read address valid.
    output logic s_axi_arready_out, // Read address ready.
    output logic [31:0] s_axi_rdata_out, // Read data.
    output logic [1:0] s_axi_rresp_out, // Read response.
    output logic s_axi_rvalid_out, // Read data valid.
    input wire logic s_axi_rready_in, // Read data ready.
    input wire logic index_pulse_in, // Index pulse, high.
    input wire logic track0_sense_in, // Track zero sense, high at track 0.
    input wire logic rd_id_valid_in, // A decoded ID field is present.
    input wire logic [31:0] rd_id_in, // Cylinder, head, sector, size.
    output logic step_out, // Step pulse.
    output logic step_direction_out, // 1 steps in.
    output logic [7:0] wr_byte_out, // Byte to write to the track.
    output logic wr_strobe_out, // Byte valid pulse.
    output logic wr_crc_out, // Insert CRC after this byte.
    output logic busy_out, // Command phase busy.
    output logic int_out // Completion interrupt for read ID, recalibrate and seek.
);
    ffsc_pkg::ffsc_state_t state;
    logic [31:0] ctrl; // Bit0 MFM, [7:1] gap 3 length, [15:8] fill, [31:24] interval; [23:16] is stored but unused.
    logic [31:0] idb; // Pending host ID bytes.
    logic [7:0] present_cylinder;
    logic [7:0] new_cylinder;
    logic [7:0] status_zero;
    logic missing_address_flag;
    logic [31:0] rid;
    logic [7:0] cnt;
    logic [15:0] len;
    logic [1:0] idx_seen;
    logic idx_d;
    logic [31:0] tick;
    logic [7:0] steps;
    logic is_recal;
    logic aw_hold, w_hold;
    logic [31:0] aw_addr, w_data;
    logic do_write, do_read;
    logic idx_rise;
    logic [2:0] wcmd;

    assign idx_rise = index_pulse_in & ~idx_d;
    assign do_write = aw_hold & w_hold & ~s_axi_bvalid_out;
    assign do_read = s_axi_arvalid_in & s_axi_arready_out;
    assign wcmd = w_data[2:0];

    // Select the MFM or FM value of a track parameter; format emits one byte per clock.
    function automatic logic [7:0] mfm_sel(input logic mfm, input logic [7:0] a, input logic [7:0] b);
        mfm_sel = mfm ? a : b;
    endfunction : mfm_sel

    // Write channel: address and data latched in either order.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            aw_hold <= 1'b0;
            w_hold <= 1'b0;
            aw_addr <= 32'h0000_0000;
            w_data <= 32'h0000_0000;
            s_axi_awready_out <= 1'b0;
            s_axi_wready_out <= 1'b0;
            s_axi_bvalid_out <= 1'b0;
            s_axi_bresp_out <= ffsc_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_awready_out <= ~aw_hold & ~s_axi_awready_out & s_axi_awvalid_in;
            s_axi_wready_out <= ~w_hold & ~s_axi_wready_out & s_axi_wvalid_in;
            if (s_axi_awvalid_in & s_axi_awready_out)
            begin
                aw_hold <= 1'b1;
                aw_addr <= s_axi_awaddr_in;
            end
            if (s_axi_wvalid_in & s_axi_wready_out)
            begin
                w_hold <= 1'b1;
                w_data <= s_axi_wdata_in;
            end
            if (do_write)
            begin
                aw_hold <= 1'b0;
                w_hold <= 1'b0;
                s_axi_bvalid_out <= 1'b1;
                s_axi_bresp_out <= (aw_addr == ffsc_pkg::ADDR_CTRL || aw_addr == ffsc_pkg::ADDR_CMD ||
                    aw_addr == ffsc_pkg::ADDR_IDB) ? ffsc_pkg::RESP_OKAY : ffsc_pkg::RESP_SLVERR;
            end
            else if (s_axi_bready_in)
            begin
                s_axi_bvalid_out <= 1'b0;
            end
        end
    end

    // Read channel; reading the sense register acknowledges the interrupt.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            s_axi_arready_out <= 1'b0;
            s_axi_rvalid_out <= 1'b0;
            s_axi_rdata_out <= 32'h0000_0000;
            s_axi_rresp_out <= ffsc_pkg::RESP_OKAY;
        end
        else
        begin
            s_axi_arready_out <= ~s_axi_arready_out & ~s_axi_rvalid_out & s_axi_arvalid_in;
            if (do_read)
            begin
                s_axi_rvalid_out <= 1'b1;
                s_axi_rresp_out <= ffsc_pkg::RESP_OKAY;
                unique case (s_axi_araddr_in)
                    ffsc_pkg::ADDR_CTRL: s_axi_rdata_out <= ctrl;
                    ffsc_pkg::ADDR_IDB: s_axi_rdata_out <= idb;
                    ffsc_pkg::ADDR_STAT: s_axi_rdata_out <= {15'h0000, missing_address_flag, new_cylinder,
                        present_cylinder};
                    ffsc_pkg::ADDR_RID: s_axi_rdata_out <= rid;
                    ffsc_pkg::ADDR_SENSE: s_axi_rdata_out <= {16'h0000, present_cylinder, status_zero};
                    default:
                    begin
                        s_axi_rdata_out <= 32'h0000_0000;
                        s_axi_rresp_out <= ffsc_pkg::RESP_SLVERR;
                    end
                endcase
            end
            else if (s_axi_rready_in)
            begin
                s_axi_rvalid_out <= 1'b0;
            end
        end
    end

    // Control register and index edge memory.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            ctrl <= 32'h0000_0001;
            idx_d <= 1'b0;
        end
        else
        begin
            idx_d <= index_pulse_in;
            if (do_write && aw_addr == ffsc_pkg::ADDR_CTRL)
            begin
                ctrl <= w_data;
            end
        end
    end

    // Command engine: format, read ID, recalibrate and seek.
    always_ff @(posedge clk_in)
    begin
        if (rst_in)
        begin
            state <= ffsc_pkg::FFSC_IDLE;
            idb <= 32'h0000_0000;
            present_cylinder <= 8'h00;
            new_cylinder <= 8'h00;
            status_zero <= 8'h00;
            missing_address_flag <= 1'b0;
            rid <= 32'h0000_0000;
            cnt <= 8'h00;
            len <= 16'h0000;
            idx_seen <= 2'h0;
            tick <= 32'h0000_0000;
            steps <= 8'h00;
            is_recal <= 1'b0;
            step_out <= 1'b0;
            step_direction_out <= 1'b0;
            wr_byte_out <= 8'h00;
            wr_strobe_out <= 1'b0;
            wr_crc_out <= 1'b0;
            busy_out <= 1'b0;
            int_out <= 1'b0;
        end
        else
        begin
            wr_strobe_out <= 1'b0;
            wr_crc_out <= 1'b0;
            step_out <= 1'b0;
            busy_out <= 1'b0;
            if (do_read && s_axi_araddr_in == ffsc_pkg::ADDR_SENSE)
            begin
                int_out <= 1'b0;
            end
            if (do_write && aw_addr == ffsc_pkg::ADDR_IDB)
            begin
                idb <= w_data;
            end
            if (do_write && aw_addr == ffsc_pkg::ADDR_CMD && state == ffsc_pkg::FFSC_IDLE)
            begin
                busy_out <= 1'b1;
                unique case (wcmd)
                    ffsc_pkg::CMD_FORMAT:
                    begin
                        state <= ffsc_pkg::FFSC_WAIT_IDX;
                    end
                    ffsc_pkg::CMD_READID:
                    begin
                        state <= ffsc_pkg::FFSC_READID;
                        idx_seen <= 2'h0;
                    end
                    ffsc_pkg::CMD_RECAL:
                    begin
                        present_cylinder <= 8'h00;
                        step_direction_out <= 1'b0;
                        is_recal <= 1'b1;
                        steps <= 8'h00;
                        tick <= 32'h0000_0000;
                        state <= ffsc_pkg::FFSC_STEP;
                    end
                    ffsc_pkg::CMD_SEEK:
                    begin
                        new_cylinder <= w_data[15:8];
                        step_direction_out <= present_cylinder < w_data[15:8];
                        is_recal <= 1'b0;
                        tick <= 32'h0000_0000;
                        state <= ffsc_pkg::FFSC_STEP;
                    end
                    ffsc_pkg::CMD_PUP:
                    begin
                        present_cylinder <= 8'h00;
                        status_zero <= 8'h00;
                        missing_address_flag <= 1'b0;
                        rid <= 32'h0000_0000;
                    end
                    default:
                    begin
                        state <= ffsc_pkg::FFSC_IDLE;
                    end
                endcase
            end
            unique case (state)
                ffsc_pkg::FFSC_IDLE:
                begin
                end
                ffsc_pkg::FFSC_WAIT_IDX:
                begin
                    if (idx_rise)
                    begin
                        state <= ffsc_pkg::FFSC_GAP4A;
                        cnt <= mfm_sel(ctrl[0], ffsc_pkg::MFM_GAP4A, ffsc_pkg::FM_GAP4A);
                    end
                end
                ffsc_pkg::FFSC_READID:
                begin
                    if (rd_id_valid_in)
                    begin
                        rid <= rd_id_in;
                        status_zero <= {2'b00, 6'h00} | {ffsc_pkg::IC_NORMAL, 6'h00};
                        int_out <= 1'b1;
                        state <= ffsc_pkg::FFSC_IDLE;
                    end
                    else if (idx_rise)
                    begin
                        idx_seen <= idx_seen + 2'h1;
                        if (idx_seen == 2'h1)
                        begin
                            status_zero <= {ffsc_pkg::IC_ABNORMAL, 6'h00};
                            missing_address_flag <= 1'b1;
                            int_out <= 1'b1;
                            state <= ffsc_pkg::FFSC_IDLE;
                        end
                    end
                end
                ffsc_pkg::FFSC_STEP:
                begin
                    tick <= tick + 32'h0000_0001;
                    if (is_recal && track0_sense_in)
                    begin
                        status_zero <= 8'h00 | (8'h01 << ffsc_pkg::ST0_SE);
                        present_cylinder <= 8'h00;
                        int_out <= 1'b1;
                        state <= ffsc_pkg::FFSC_IDLE;
                    end
                    else if (is_recal && steps == ffsc_pkg::RECAL_MAX)
                    begin
                        status_zero <= {ffsc_pkg::IC_ABNORMAL, 6'h00} | (8'h01 << ffsc_pkg::ST0_SE) |
                            (8'h01 << ffsc_pkg::ST0_EC);
                        int_out <= 1'b1;
                        state <= ffsc_pkg::FFSC_IDLE;
                    end
                    else if (!is_recal && present_cylinder == new_cylinder)
                    begin
                        status_zero <= 8'h00 | (8'h01 << ffsc_pkg::ST0_SE);
                        int_out <= 1'b1;
                        state <= ffsc_pkg::FFSC_IDLE;
                    end
                    else if (tick >= 32'(ctrl[31:24]) * 32'(STEP_DIV))
                    begin
                        tick <= 32'h0000_0000;
                        step_out <= 1'b1;
                        if (is_recal)
                        begin
                            steps <= steps + 8'h01;
                        end
                        else
                        begin
                            step_direction_out <= present_cylinder < new_cylinder;
                            present_cylinder <= (present_cylinder < new_cylinder) ? present_cylinder + 8'h01 :
                                present_cylinder - 8'h01;
                        end
                    end
                end
                default:
                begin
                    // Track byte emission for format.
                    wr_strobe_out <= 1'b1;
                    cnt <= cnt - 8'h01;
                    unique case (state)
                        ffsc_pkg::FFSC_GAP4A, ffsc_pkg::FFSC_GAP1, ffsc_pkg::FFSC_GAP2, ffsc_pkg::FFSC_GAP3:
                            wr_byte_out <= mfm_sel(ctrl[0], ffsc_pkg::GAP_MFM, ffsc_pkg::GAP_FM);
                        ffsc_pkg::FFSC_SYNC_I, ffsc_pkg::FFSC_SYNC_ID, ffsc_pkg::FFSC_SYNC_D:
                            wr_byte_out <= ffsc_pkg::SYNC_BYTE;
                        ffsc_pkg::FFSC_IAM:
                            wr_byte_out <= (cnt == 8'h01) ? ffsc_pkg::MARK_INDEX : ffsc_pkg::IAM_MFM_PRE;
                        ffsc_pkg::FFSC_ID_MARK:
                            wr_byte_out <= (cnt == 8'h01) ? ffsc_pkg::MARK_ID : ffsc_pkg::IDM_MFM_PRE;
                        ffsc_pkg::FFSC_DAM:
                            wr_byte_out <= (cnt == 8'h01) ? ffsc_pkg::MARK_DATA : ffsc_pkg::IDM_MFM_PRE;
                        ffsc_pkg::FFSC_IDF:
                        begin
                            wr_byte_out <= idb[8'(cnt - 8'h01) * 8 +: 8];
                            wr_crc_out <= cnt == 8'h01;
                        end
                        default:
                        begin
                            wr_byte_out <= ctrl[15:8];
                            wr_crc_out <= len == 16'h0001;
                            len <= len - 16'h0001;
                        end
                    endcase
                    if (idx_rise && state != ffsc_pkg::FFSC_GAP4A && state != ffsc_pkg::FFSC_SYNC_I)
                    begin
                        status_zero <= {ffsc_pkg::IC_NORMAL, 6'h00};
                        state <= ffsc_pkg::FFSC_IDLE;
                        wr_strobe_out <= 1'b0;
                    end
                    else if (state == ffsc_pkg::FFSC_DATA ? len == 16'h0001 : cnt == 8'h01)
                    begin
                        unique case (state)
                            ffsc_pkg::FFSC_GAP4A:
                            begin
                                state <= ffsc_pkg::FFSC_SYNC_I;
                                cnt <= mfm_sel(ctrl[0], ffsc_pkg::MFM_SYNC, ffsc_pkg::FM_SYNC);
                            end
                            ffsc_pkg::FFSC_SYNC_I:
                            begin
                                state <= ffsc_pkg::FFSC_IAM;
                                cnt <= ctrl[0] ? ffsc_pkg::PREFIX_CNT + 8'h01 : 8'h01;
                            end
                            ffsc_pkg::FFSC_IAM:
                            begin
                                state <= ffsc_pkg::FFSC_GAP1;
                                cnt <= mfm_sel(ctrl[0], ffsc_pkg::MFM_GAP1, ffsc_pkg::FM_GAP1);
                            end
                            ffsc_pkg::FFSC_GAP1, ffsc_pkg::FFSC_GAP3:
                            begin
                                state <= ffsc_pkg::FFSC_SYNC_ID;
                                cnt <= mfm_sel(ctrl[0], ffsc_pkg::MFM_SYNC, ffsc_pkg::FM_SYNC);
                            end
                            ffsc_pkg::FFSC_SYNC_ID:
                            begin
                                state <= ffsc_pkg::FFSC_ID_MARK;
                                cnt <= ctrl[0] ? ffsc_pkg::PREFIX_CNT + 8'h01 : 8'h01;
                            end
                            ffsc_pkg::FFSC_ID_MARK:
                            begin
                                state <= ffsc_pkg::FFSC_IDF;
                                cnt <= 8'h04;
                            end
                            ffsc_pkg::FFSC_IDF:
                            begin
                                state <= ffsc_pkg::FFSC_GAP2;
                                cnt <= mfm_sel(ctrl[0], ffsc_pkg::MFM_GAP2, ffsc_pkg::FM_GAP2);
                            end
                            ffsc_pkg::FFSC_GAP2:
                            begin
                                state <= ffsc_pkg::FFSC_SYNC_D;
                                cnt <= mfm_sel(ctrl[0], ffsc_pkg::MFM_SYNC, ffsc_pkg::FM_SYNC);
                            end
                            ffsc_pkg::FFSC_SYNC_D:
                            begin
                                state <= ffsc_pkg::FFSC_DAM;
                                cnt <= ctrl[0] ? ffsc_pkg::PREFIX_CNT + 8'h01 : 8'h01;
                            end
                            ffsc_pkg::FFSC_DAM:
                            begin
                                state <= ffsc_pkg::FFSC_DATA;
                                len <= 16'h0080 << idb[2:0];
                            end
                            default:
                            begin
                                state <= ffsc_pkg::FFSC_GAP3;
                                cnt <= ctrl[7:1] == 7'h00 ? 8'h01 : {1'b0, ctrl[7:1]};
                            end
                        endcase
                    end
                end
            endcase
        end
    end
endmodule : ffsc_top
